// ===== verilog/hwc_defs.svh
// offsets, field positions, reset values and timing counts of the configuration block
`ifndef HWC_DEFS_SVH
`define HWC_DEFS_SVH

`define HWC_OFF_HARDWARE_CONFIGURATION        8'h10
`define HWC_OFF_EE_CMD        8'hb0

`define HWC_BIT_FULL_RST      0
`define HWC_BIT_LITE_RST      1
`define HWC_BIT_TO_SEL        3
`define HWC_BIT_PACK          4
`define HWC_BIT_SLEEP_POL     5
`define HWC_BIT_SLEEP_MODE    6
`define HWC_BIT_PROTECT       12
`define HWC_BIT_EMUL          13
`define HWC_BIT_DETACH        15
`define HWC_BIT_REF_EN        24
`define HWC_BIT_FAST_EN       25
`define HWC_BIT_EE_TO_FLAG    0

`define HWC_IMG_FAST          0
`define HWC_IMG_REF           1
`define HWC_IMG_MODE          2
`define HWC_IMG_POL           4
`define HWC_IMG_RESET         5'h00

`define HWC_MODE_RESET        2'h0
`define HWC_MODE_L2           2'h0
`define HWC_MODE_L1           2'h1
`define HWC_MODE_L0           2'h2
`define HWC_MODE_L3           2'h3

`define HWC_CLK_MHZ           200
`define HWC_CLK_PERIOD_NS     5
`define HWC_EE_TO_LONG_MS     30
`define HWC_EE_TO_SHORT_NS    1280
`define HWC_EE_TO_SHORT_CYC   ((`HWC_EE_TO_SHORT_NS * `HWC_CLK_MHZ) / 1000)
`define HWC_EE_TO_LONG_CYC    (`HWC_EE_TO_LONG_MS * `HWC_CLK_MHZ * 1000)
`define HWC_REF_MHZ           25
`define HWC_REF_HALF_CYC      (1000 / (2 * `HWC_REF_MHZ * `HWC_CLK_PERIOD_NS))
`define HWC_LITE_CYC          8'h10
`define HWC_SETTLE_CYC        8'h10

`endif

// ===== verilog/hwc_pkg.sv
// types of the configuration and soft reset block
package hwc_pkg;
    typedef enum logic [1:0] {
        HWC_IDLE,
        HWC_LITE,
        HWC_FULL_LOAD,
        HWC_FULL_SETTLE
    } hwc_seq_t;
endpackage

// ===== verilog/hwc_config.sv
// hardware configuration register, soft resets, sleep pin and eeprom timeout
`timescale 1ns/100ps
`default_nettype none
`include "hwc_defs.svh"

module hwc_config
    import hwc_pkg::*;
#(
    parameter int unsigned EE_TO_LONG_CYCLES = `HWC_EE_TO_LONG_CYC
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        eepromPresent,
    input  wire logic        otpConfigured,
    input  wire logic        imageLoad,
    input  wire logic [4:0]  eepromImage,
    input  wire logic [4:0]  otpImage,
    output logic             imageReloadReq,
    input  wire logic        usbReset,
    input  wire logic        detachOccurred,
    input  wire logic        detachEvent,
    input  wire logic        sleepLevel0,
    input  wire logic        sleepLevel1,
    input  wire logic        sleepLevel2,
    input  wire logic        sleepLevel3,
    input  wire logic        cableDetached,
    output logic             sleepPin,
    output logic             useDescriptorRam,
    output logic             framePackingEnable,
    input  wire logic        eepromAccessStart,
    input  wire logic        eepromResponse,
    output logic             eepromTimeout,
    output logic             liteResetActive,
    output logic             fullResetActive,
    output logic             phyDisconnect,
    output logic             internalFastClockEnable,
    output logic             referenceClockOutput
);

    localparam logic [22:0] EE_LONG  = 23'(EE_TO_LONG_CYCLES);
    localparam logic [22:0] EE_SHORT = 23'(`HWC_EE_TO_SHORT_CYC);
    localparam logic [1:0]  REF_HALF = 2'(`HWC_REF_HALF_CYC - 1);

    // configuration register group
    logic        emulSelQ, emulSelD;
    logic        protectQ, protectD;
    logic [1:0]  modeQ, modeD;
    logic        polQ, polD;
    logic        packQ, packD;
    logic        toSelQ, toSelD;
    logic        detachQ, detachD;
    logic        fastEnQ, fastEnD;
    logic        refEnQ, refEnD;
    logic [4:0]  imageQ, imageD;
    logic        startupQ, startupD;
    logic        initPendQ, initPendD;
    hwc_seq_t    seqQ, seqD;
    logic [7:0]  seqCntQ, seqCntD;
    logic        reloadQ, reloadD;
    logic        restore;

    // bus group
    logic        ackQ, ackD;
    logic [31:0] datQ, datD;
    logic [31:0] readVal;
    logic        wrCfg, wrEe;

    // eeprom timeout group
    logic        eeBusyQ, eeBusyD;
    logic [22:0] eeCntQ, eeCntD;
    logic        eeFlagQ, eeFlagD;
    logic        eeToQ, eeToD;
    logic [22:0] eeLimit;

    // pin group
    logic        sleepQ, sleepD;
    logic        sleepAssert;
    logic [1:0]  divQ, divD;
    logic        refClkQ, refClkD;

    assign wrCfg = wb_cyc_i && wb_stb_i && wb_we_i && ackQ && (wb_adr_i == `HWC_OFF_HARDWARE_CONFIGURATION);
    assign wrEe  = wb_cyc_i && wb_stb_i && wb_we_i && ackQ && (wb_adr_i == `HWC_OFF_EE_CMD);

    always_comb begin
        emulSelD  = emulSelQ;
        protectD  = protectQ;
        modeD     = modeQ;
        polD      = polQ;
        packD     = packQ;
        toSelD    = toSelQ;
        detachD   = detachQ;
        fastEnD   = fastEnQ;
        refEnD    = refEnQ;
        imageD    = imageQ;
        startupD  = 1'b0;
        initPendD = initPendQ;
        seqD      = seqQ;
        seqCntD   = seqCntQ;
        reloadD   = 1'b0;
        restore   = 1'b0;
        if (imageLoad) begin
            if (eepromPresent) begin
                imageD = eepromImage;
            end else if (otpConfigured) begin
                imageD = otpImage;
            end else begin
                imageD = `HWC_IMG_RESET;
            end
        end
        // power-on defaults come from the first image, protection ignored
        if (initPendQ && imageLoad) begin
            initPendD = 1'b0;
            fastEnD   = imageD[`HWC_IMG_FAST];
            refEnD    = imageD[`HWC_IMG_REF];
            modeD     = imageD[`HWC_IMG_MODE +: 2];
            polD      = imageD[`HWC_IMG_POL];
        end
        // detach level is caught on the first clock after power-on release
        if (startupQ) begin
            detachD = detachOccurred;
        end
        // reserved bits are simply not decoded
        if (wrCfg) begin
            if (wb_sel_i[0]) begin
                toSelD = wb_dat_i[`HWC_BIT_TO_SEL];
                packD  = wb_dat_i[`HWC_BIT_PACK];
                polD   = wb_dat_i[`HWC_BIT_SLEEP_POL];
                modeD  = wb_dat_i[`HWC_BIT_SLEEP_MODE +: 2];
            end
            if (wb_sel_i[1]) begin
                protectD = wb_dat_i[`HWC_BIT_PROTECT];
                emulSelD = wb_dat_i[`HWC_BIT_EMUL];
                if (wb_dat_i[`HWC_BIT_DETACH]) begin
                    detachD = 1'b0;
                end
            end
            if (wb_sel_i[3]) begin
                refEnD  = wb_dat_i[`HWC_BIT_REF_EN];
                fastEnD = wb_dat_i[`HWC_BIT_FAST_EN];
            end
        end
        // a new detach event beats a clear in the same cycle
        if (detachEvent) begin
            detachD = 1'b1;
        end
        case (seqQ)
            HWC_IDLE: begin
                // full reset wins if both start bits are written together
                if (wrCfg && wb_sel_i[0] && wb_dat_i[`HWC_BIT_FULL_RST]) begin
                    seqD    = HWC_FULL_LOAD;
                    reloadD = 1'b1;
                end else if (wrCfg && wb_sel_i[0] && wb_dat_i[`HWC_BIT_LITE_RST]) begin
                    seqD    = HWC_LITE;
                    seqCntD = 8'h00;
                end
            end
            HWC_LITE: begin
                seqCntD = seqCntQ + 8'h01;
                if (seqCntQ == `HWC_LITE_CYC - 8'h01) begin
                    seqD    = HWC_IDLE;
                    restore = 1'b1;
                end
            end
            HWC_FULL_LOAD: begin
                if (imageLoad) begin
                    seqD    = HWC_FULL_SETTLE;
                    seqCntD = 8'h00;
                end
            end
            HWC_FULL_SETTLE: begin
                seqCntD = seqCntQ + 8'h01;
                if (seqCntQ == `HWC_SETTLE_CYC - 8'h01) begin
                    seqD    = HWC_IDLE;
                    restore = 1'b1;
                end
            end
            default: begin
                seqD = HWC_IDLE;
            end
        endcase
        if (usbReset) begin
            restore = 1'b1;
        end
        // restore at the end of a lite or full reset sequence and on usb reset
        if (restore) begin
            packD  = 1'b0;
            toSelD = 1'b0;
            if (!protectQ) begin
                emulSelD = 1'b0;
                protectD = 1'b0;
                fastEnD  = imageD[`HWC_IMG_FAST];
                refEnD   = imageD[`HWC_IMG_REF];
                modeD    = imageD[`HWC_IMG_MODE +: 2];
                polD     = imageD[`HWC_IMG_POL];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            emulSelQ  <= 1'b0;
            protectQ  <= 1'b0;
            modeQ     <= `HWC_MODE_RESET;
            polQ      <= 1'b0;
            packQ     <= 1'b0;
            toSelQ    <= 1'b0;
            detachQ   <= 1'b0;
            fastEnQ   <= 1'b0;
            refEnQ    <= 1'b0;
            imageQ    <= `HWC_IMG_RESET;
            startupQ  <= 1'b1;
            initPendQ <= 1'b1;
            seqQ      <= HWC_IDLE;
            seqCntQ   <= 8'h00;
            reloadQ   <= 1'b0;
        end else begin
            emulSelQ  <= emulSelD;
            protectQ  <= protectD;
            modeQ     <= modeD;
            polQ      <= polD;
            packQ     <= packD;
            toSelQ    <= toSelD;
            detachQ   <= detachD;
            fastEnQ   <= fastEnD;
            refEnQ    <= refEnD;
            imageQ    <= imageD;
            startupQ  <= startupD;
            initPendQ <= initPendD;
            seqQ      <= seqD;
            seqCntQ   <= seqCntD;
            reloadQ   <= reloadD;
        end
    end

    always_comb begin
        readVal = 32'h0000_0000;
        if (wb_adr_i == `HWC_OFF_HARDWARE_CONFIGURATION) begin
            readVal[`HWC_BIT_FULL_RST]       = (seqQ == HWC_FULL_LOAD) || (seqQ == HWC_FULL_SETTLE);
            readVal[`HWC_BIT_LITE_RST]       = (seqQ == HWC_LITE);
            readVal[`HWC_BIT_TO_SEL]         = toSelQ;
            readVal[`HWC_BIT_PACK]           = packQ;
            readVal[`HWC_BIT_SLEEP_POL]      = polQ;
            readVal[`HWC_BIT_SLEEP_MODE +: 2] = modeQ;
            readVal[`HWC_BIT_PROTECT]        = protectQ;
            readVal[`HWC_BIT_EMUL]           = emulSelQ;
            readVal[`HWC_BIT_DETACH]         = detachQ;
            readVal[`HWC_BIT_REF_EN]         = refEnQ;
            readVal[`HWC_BIT_FAST_EN]        = fastEnQ;
        end else if (wb_adr_i == `HWC_OFF_EE_CMD) begin
            readVal[`HWC_BIT_EE_TO_FLAG]     = eeFlagQ;
        end
        // one wait state; ack falls the cycle after it was given
        ackD = wb_cyc_i && wb_stb_i && !ackQ;
        datD = ackD ? readVal : 32'h0000_0000;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ackQ <= 1'b0;
            datQ <= 32'h0000_0000;
        end else begin
            ackQ <= ackD;
            datQ <= datD;
        end
    end

    always_comb begin
        eeLimit = toSelQ ? EE_SHORT : EE_LONG;
        eeBusyD = eeBusyQ;
        eeCntD  = eeCntQ;
        eeFlagD = eeFlagQ;
        eeToD   = 1'b0;
        if (wrEe && wb_sel_i[0] && wb_dat_i[`HWC_BIT_EE_TO_FLAG]) begin
            eeFlagD = 1'b0;
        end
        if (eepromAccessStart) begin
            eeBusyD = 1'b1;
            eeCntD  = 23'h000000;
        end else if (eeBusyQ && eepromResponse) begin
            eeBusyD = 1'b0;
        end else if (eeBusyQ) begin
            eeCntD = eeCntQ + 23'h000001;
            if (eeCntQ == eeLimit - 23'h000001) begin
                eeBusyD = 1'b0;
                eeToD   = 1'b1;
                eeFlagD = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            eeBusyQ <= 1'b0;
            eeCntQ  <= 23'h000000;
            eeFlagQ <= 1'b0;
            eeToQ   <= 1'b0;
        end else begin
            eeBusyQ <= eeBusyD;
            eeCntQ  <= eeCntD;
            eeFlagQ <= eeFlagD;
            eeToQ   <= eeToD;
        end
    end

    always_comb begin
        case (modeQ)
            `HWC_MODE_L2: sleepAssert = sleepLevel2;
            `HWC_MODE_L1: sleepAssert = sleepLevel2 || sleepLevel1 || cableDetached;
            `HWC_MODE_L0: sleepAssert = sleepLevel2 || sleepLevel1 || sleepLevel0
                                        || cableDetached;
            `HWC_MODE_L3: sleepAssert = sleepLevel3 || sleepLevel2 || sleepLevel1
                                        || sleepLevel0 || cableDetached;
            default:      sleepAssert = 1'b0;
        endcase
        sleepD = polQ ? sleepAssert : !sleepAssert;
        // 200 MHz divided by eight gives the 25 MHz reference
        divD    = 2'h0;
        refClkD = 1'b0;
        if (refEnQ) begin
            divD    = (divQ == REF_HALF) ? 2'h0 : divQ + 2'h1;
            refClkD = (divQ == REF_HALF) ? !refClkQ : refClkQ;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sleepQ  <= 1'b1;
            divQ    <= 2'h0;
            refClkQ <= 1'b0;
        end else begin
            sleepQ  <= sleepD;
            divQ    <= divD;
            refClkQ <= refClkD;
        end
    end

    assign wb_ack_o                = ackQ;
    assign wb_dat_o                = datQ;
    assign sleepPin                = sleepQ;
    assign referenceClockOutput    = refClkQ;
    assign eepromTimeout           = eeToQ;
    assign imageReloadReq          = reloadQ;
    // the 125 MHz generator itself sits in the clock unit
    assign internalFastClockEnable = fastEnQ;
    assign framePackingEnable      = packQ;
    assign useDescriptorRam        = emulSelQ && !eepromPresent && !otpConfigured;
    assign liteResetActive         = (seqQ == HWC_LITE);
    assign fullResetActive         = (seqQ == HWC_FULL_LOAD) || (seqQ == HWC_FULL_SETTLE);
    assign phyDisconnect           = fullResetActive;

endmodule
`default_nettype wire

// ===== test/hwc_config_checker.sv
// assertion checker for the configuration register block
`timescale 1ns/100ps
`default_nettype none
module hwc_config_checker #(
    parameter int unsigned EE_TO_LONG_CYCLES = 300
) (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        eepromPresent,
    input wire logic        otpConfigured,
    input wire logic        imageReloadReq,
    input wire logic        useDescriptorRam,
    input wire logic        eepromAccessStart,
    input wire logic        eepromTimeout,
    input wire logic        liteResetActive,
    input wire logic        fullResetActive,
    input wire logic        phyDisconnect,
    input wire logic        referenceClockOutput
);
    logic [4:0]  liteCnt_q, liteCnt_d;
    logic [31:0] toCnt_q, toCnt_d;

    // cycles spent in lite reset, and cycles since the last eeprom start
    always_comb begin
        liteCnt_d = liteResetActive ? liteCnt_q + 5'h01 : 5'h00;
        toCnt_d = eepromAccessStart ? 32'h0 : toCnt_q + 32'h1;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            liteCnt_q <= 5'h00;
            toCnt_q <= 32'h0;
        end else begin
            liteCnt_q <= liteCnt_d;
            toCnt_q <= toCnt_d;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_ack_answer: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
        else $error("bus request not answered one cycle later");
    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    chk_desc_gate: assert property (useDescriptorRam |-> !eepromPresent && !otpConfigured)
        else $error("descriptor ram used with eeprom or otp present");
    chk_phy_full: assert property (phyDisconnect == fullResetActive)
        else $error("phy disconnect differs from full reset state");
    chk_lite_phy: assert property (liteResetActive |-> !phyDisconnect && !fullResetActive)
        else $error("lite reset disconnected the phy");
    chk_full_reload: assert property ($rose(fullResetActive) |-> imageReloadReq)
        else $error("full reset began without reload request");
    chk_lite_len: assert property ($fell(liteResetActive) |-> liteCnt_q == 5'h10)
        else $error("lite reset did not last sixteen cycles");
    chk_to_window: assert property (eepromTimeout |-> (toCnt_q >= 32'hfe && toCnt_q <= 32'h101)
        || (toCnt_q + 32'h2 >= EE_TO_LONG_CYCLES && toCnt_q <= EE_TO_LONG_CYCLES + 32'h1))
        else $error("eeprom timeout at wrong distance from start");
    chk_to_pulse: assert property (eepromTimeout |=> !eepromTimeout)
        else $error("eeprom timeout longer than one cycle");
    chk_ref_toggle: assert property ($rose(referenceClockOutput) |-> ##4 !referenceClockOutput)
        else $error("reference clock high phase too long");
endmodule
`default_nettype wire

// ===== test/hwc_config_tb.sv
// self-checking bench for the configuration register block
`timescale 1ns/100ps
`default_nettype none
`include "hwc_defs.svh"
module hwc_config_tb;
    localparam int unsigned LONG = 300;
    typedef struct packed {logic [1:0] mode; logic pol; logic [3:0] lvl; logic det; logic pin;} hwc_row_t;
    logic        clk, rst_n, cyc, stb, we, ack, eePres, otpCfg, imgLoad, reloadReq, usbRst;
    logic        detOcc, detEvt, detached, sleepPin, useRam, pack, eeStart, eeResp, eeTo;
    logic        liteAct, fullAct, phyDis, fastEn, refOut;
    logic [7:0]  adr;
    logic [3:0]  sel, lvl;
    logic [4:0]  eeImg, otpImg;
    logic [31:0] datI, datO, v;
    int          nErrors, samplesChecked, n;
    // mode, polarity, levels 3..0, detached, expected pin
    hwc_row_t    rows [9] = '{'{2'h0, 1'b0, 4'h4, 1'b0, 1'b0}, '{2'h0, 1'b0, 4'h2, 1'b0, 1'b1},
        '{2'h1, 1'b0, 4'h2, 1'b0, 1'b0}, '{2'h1, 1'b1, 4'h0, 1'b1, 1'b1},
        '{2'h1, 1'b1, 4'h1, 1'b0, 1'b0}, '{2'h2, 1'b1, 4'h1, 1'b0, 1'b1},
        '{2'h2, 1'b0, 4'h8, 1'b0, 1'b1}, '{2'h3, 1'b0, 4'h8, 1'b0, 1'b0},
        '{2'h3, 1'b1, 4'h0, 1'b0, 1'b0}};

    hwc_config #(.EE_TO_LONG_CYCLES(LONG)) dut_u (
        .clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack),
        .eepromPresent(eePres), .otpConfigured(otpCfg), .imageLoad(imgLoad),
        .eepromImage(eeImg), .otpImage(otpImg), .imageReloadReq(reloadReq), .usbReset(usbRst),
        .detachOccurred(detOcc), .detachEvent(detEvt), .sleepLevel0(lvl[0]),
        .sleepLevel1(lvl[1]), .sleepLevel2(lvl[2]), .sleepLevel3(lvl[3]),
        .cableDetached(detached), .sleepPin(sleepPin), .useDescriptorRam(useRam),
        .framePackingEnable(pack), .eepromAccessStart(eeStart), .eepromResponse(eeResp),
        .eepromTimeout(eeTo), .liteResetActive(liteAct), .fullResetActive(fullAct),
        .phyDisconnect(phyDis), .internalFastClockEnable(fastEn), .referenceClockOutput(refOut));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            nErrors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one classic cycle, held until ack is sampled high
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int t;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        datI <= d;
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (ack !== 1'b1 && t < 20);
        if (t >= 20) nErrors++;
        q = datO;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(q, e);
    endtask

    // bounded wait, n reaches 1000 if the level never comes
    task automatic waitLvl(ref logic s, input logic lv, output int c);
        c = 0;
        while (s !== lv && c < 1000) begin
            @(posedge clk);
            c++;
        end
    endtask

    // one-cycle strobe: 0 image load, 1 usb reset, 2 eeprom start, 3 response, 4 detach
    task automatic pulse(input int w);
        @(posedge clk);
        {detEvt, eeResp, eeStart, usbRst, imgLoad} <= 5'(1 << w);
        @(posedge clk);
        {detEvt, eeResp, eeStart, usbRst, imgLoad} <= 5'h00;
    endtask

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", samplesChecked, nErrors);
        if (nErrors == 0 && samplesChecked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        nErrors++;
        $display("ERROR at %0t: watchdog expired", $time);
        summarize();
    end

    initial begin
        {rst_n, cyc, stb, we, adr, datI, eePres, otpCfg, imgLoad, usbRst} = '0;
        {detEvt, lvl, detached, eeStart, eeResp} = '0;
        sel = 4'hf;
        detOcc = 1'b1;
        eeImg = 5'h1b;
        otpImg = 5'h04;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        check({26'h0, sleepPin, fastEn, liteAct, fullAct, phyDis, eeTo}, 32'h20);
        rdChk(`HWC_OFF_HARDWARE_CONFIGURATION, 32'h00008000);
        eePres <= 1'b1;
        pulse(0);
        rdChk(`HWC_OFF_HARDWARE_CONFIGURATION, 32'h030080a0);
        check({31'h0, fastEn}, 32'h1);
        $display("reset and image load done");
        for (int i = 0; i < 9; i++) begin
            lvl <= rows[i].lvl;
            detached <= rows[i].det;
            v = 32'h01000000 | (32'(i % 2) * 32'h2010) | (32'(rows[i].mode) << 6)
                | (32'(rows[i].pol) << 5);
            // reserved positions written high must not stick
            wr(`HWC_OFF_HARDWARE_CONFIGURATION, v | 32'hfcff0f04);
            repeat (3) @(posedge clk);
            check({31'h0, sleepPin}, {31'h0, rows[i].pin});
            check({31'h0, pack}, 32'(i % 2));
            check({31'h0, useRam}, 32'h0);
            rdChk(`HWC_OFF_HARDWARE_CONFIGURATION, v | 32'h8000);
        end
        $display("sleep pin table done");
        eePres <= 1'b0;
        wr(`HWC_OFF_HARDWARE_CONFIGURATION, 32'h2000);
        repeat (2) @(posedge clk);
        check({31'h0, useRam}, 32'h1);
        otpCfg <= 1'b1;
        repeat (2) @(posedge clk);
        check({31'h0, useRam}, 32'h0);
        otpCfg <= 1'b0;
        $display("emulation select done");
        wr(`HWC_OFF_HARDWARE_CONFIGURATION, 32'h30f0);
        wr(`HWC_OFF_HARDWARE_CONFIGURATION, 32'h30f2);
        waitLvl(liteAct, 1'b1, n);
        rdChk(`HWC_OFF_HARDWARE_CONFIGURATION, 32'hb0f2);
        waitLvl(liteAct, 1'b0, n);
        rdChk(`HWC_OFF_HARDWARE_CONFIGURATION, 32'hb0e0);
        wr(`HWC_OFF_HARDWARE_CONFIGURATION, 32'h2070);
        pulse(1);
        repeat (3) @(posedge clk);
        rdChk(`HWC_OFF_HARDWARE_CONFIGURATION, 32'h030080a0);
        $display("lite and usb reset done");
        wr(`HWC_OFF_HARDWARE_CONFIGURATION, 32'h1);
        waitLvl(fullAct, 1'b1, n);
        check({31'h0, phyDis}, 32'h1);
        // a lite start while the full sequence runs is refused
        wr(`HWC_OFF_HARDWARE_CONFIGURATION, 32'h2);
        otpCfg <= 1'b1;
        pulse(0);
        waitLvl(fullAct, 1'b0, n);
        check({30'h0, liteAct, phyDis}, 32'h0);
        rdChk(`HWC_OFF_HARDWARE_CONFIGURATION, 32'h8040);
        $display("full reset done");
        for (int k = 0; k < 2; k++) begin
            wr(`HWC_OFF_HARDWARE_CONFIGURATION, k ? 32'h0 : 32'h8);
            pulse(2);
            waitLvl(eeTo, 1'b1, n);
            check({31'h0, (n > (k ? LONG : 256) - 5 && n < (k ? LONG : 256) + 3)}, 32'h1);
            rdChk(`HWC_OFF_EE_CMD, 32'h1);
            wr(`HWC_OFF_EE_CMD, 32'h1);
            rdChk(`HWC_OFF_EE_CMD, 32'h0);
        end
        pulse(2);
        repeat (10) @(posedge clk);
        pulse(3);
        waitLvl(eeTo, 1'b1, n);
        check(32'(n), 32'd1000);
        $display("eeprom timeout done");
        // detach status: write one clears, a new event sets it again
        wr(`HWC_OFF_HARDWARE_CONFIGURATION, 32'h8000);
        rdChk(`HWC_OFF_HARDWARE_CONFIGURATION, 32'h0);
        pulse(4);
        rdChk(`HWC_OFF_HARDWARE_CONFIGURATION, 32'h8000);
        wr(8'h44, 32'hffffffff);
        rdChk(8'h44, 32'h0);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rdChk(`HWC_OFF_HARDWARE_CONFIGURATION, 32'h8000);
        $display("unmapped access and second reset done");
        summarize();
    end
endmodule

bind hwc_config hwc_config_checker #(.EE_TO_LONG_CYCLES(EE_TO_LONG_CYCLES)) chkU (
    .clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .eepromPresent(eepromPresent), .otpConfigured(otpConfigured),
    .imageReloadReq(imageReloadReq), .useDescriptorRam(useDescriptorRam),
    .eepromAccessStart(eepromAccessStart), .eepromTimeout(eepromTimeout),
    .liteResetActive(liteResetActive), .fullResetActive(fullResetActive),
    .phyDisconnect(phyDisconnect), .referenceClockOutput(referenceClockOutput));
`default_nettype wire
